// ### timer_event_ctrl.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timer_event_ctrl (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // timer side
  input wire logic [1:0] protect_level_i,
  input wire logic timer_input_one_i,
  input wire logic timer_input_two_i,
  input wire logic internal_trigger_source_i,
  input wire logic trigger_in_i,
  // events and outputs
  output logic ch1_output_reference_o,
  output logic update_event_o,
  output logic trigger_event_o,
  output logic [3:0] cc_irq_req_o,
  output logic [3:0] cc_dma_req_o,
  output logic [15:0] counter_value_o
);
  import timer_evt_pkg::*;

  typedef struct packed {
    logic bus_wait;
    logic [31:0] rdata;
    logic [15:0] control;
    logic [15:0] int_enable;
    logic [15:0] status;
    logic [15:0] event_gen;
    logic [15:0] mode_a;
    logic [15:0] mode_b;
    logic [15:0] ch_enable;
    logic [15:0] counter;
    logic [15:0] prescale;
    logic [15:0] psc_count;
    logic [15:0] reload;
    logic [3:0][15:0] cc_val;
    logic [15:0] cmp1_active;
    logic center_down;
    logic ch1_ref;
    logic [1:0] t1_sync;
    logic [1:0] t2_sync;
    logic ic1_prev;
    logic upd_evt;
    logic trg_evt;
    logic [3:0] irq;
    logic [3:0] dma;
  } state_type;

  state_type st;
  state_type next_st;
  logic wr;
  logic rd;
  logic [15:0] wd;
  logic [15:0] wmask;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [15:0] mode_new;
  logic [1:0] cc_idx;
  logic cc_hit;
  logic tick;
  logic upd;
  logic trg;
  logic ic1_src;
  logic ic1_edge;
  logic ch_evt;
  logic cap;
  logic m1;
  logic [1:0] dir1;
  logic [31:0] rmux;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] m);
    return (old & ~m) | (val & m);
  endfunction : merge16

  function automatic logic [1:0] chan_dir(input logic [1:0] i,
                                          input logic [15:0] ma,
                                          input logic [15:0] mb);
    logic [1:0] d;
    case (i)
      2'h0: d = ma[DIR_LSB +: 2];
      2'h1: d = ma[DIR2_LSB +: 2];
      2'h2: d = mb[DIR_LSB +: 2];
      default: d = mb[DIR2_LSB +: 2];
    endcase
    return d;
  endfunction : chan_dir

  assign dir1 = st.mode_a[DIR_LSB +: 2];
  assign cc_hit = (avs_address_i >= OFS_CC1) && (avs_address_i <= OFS_CC4)
                  && (avs_address_i[1:0] == 2'h0);
  assign cc_idx = 2'((avs_address_i - OFS_CC1) >> 2);

  always_comb begin
    next_st = st;
    next_st.upd_evt = 1'b0;
    next_st.trg_evt = 1'b0;
    next_st.irq = 4'h0;
    next_st.dma = 4'h0;
    next_st.event_gen = RST_ZERO;
    flag_set = RST_ZERO;
    flag_clr = RST_ZERO;
    mode_new = st.mode_a;
    tick = 1'b0;
    upd = 1'b0;
    m1 = 1'b0;
    ch_evt = 1'b0;
    cap = 1'b0;
    rmux = 32'h0000_0000;
    wr = avs_write_i & ~st.bus_wait;
    rd = avs_read_i & ~st.bus_wait;
    wd = avs_writedata_i[15:0];
    wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // pin synchronisers
    next_st.t1_sync = {st.t1_sync[0], timer_input_one_i};
    next_st.t2_sync = {st.t2_sync[0], timer_input_two_i};
    case (dir_type'(dir1))
      DIR_INPUT_OWN: ic1_src = st.t1_sync[1];
      DIR_INPUT_NEIGHBOUR: ic1_src = st.t2_sync[1];
      DIR_INPUT_TRIGGER: ic1_src = internal_trigger_source_i;
      default: ic1_src = 1'b0;
    endcase
    next_st.ic1_prev = ic1_src;
    ic1_edge = ic1_src & ~st.ic1_prev;
    // counter and prescaler
    if (st.event_gen[EG_UPDATE_BIT]) begin
      upd = 1'b1;
      next_st.psc_count = RST_ZERO;
      next_st.center_down = 1'b0;
      if (st.control[CTL_DOWN_BIT]
          && st.control[CTL_CENTER_LSB +: 2] == 2'h0) begin
        next_st.counter = st.reload;
      end else begin
        next_st.counter = RST_ZERO;
      end
    end else if (st.control[CTL_COUNT_EN_BIT]) begin
      if (st.psc_count == st.prescale) begin
        next_st.psc_count = RST_ZERO;
        tick = 1'b1;
      end else begin
        next_st.psc_count = st.psc_count + 16'h0001;
      end
    end
    if (tick) begin
      if (st.control[CTL_CENTER_LSB +: 2] != 2'h0) begin
        if (st.center_down) begin
          next_st.counter = st.counter - 16'h0001;
          if (st.counter == 16'h0001) begin
            next_st.center_down = 1'b0;
            upd = 1'b1;
          end
        end else begin
          next_st.counter = st.counter + 16'h0001;
          if (st.counter + 16'h0001 >= st.reload) begin
            next_st.center_down = 1'b1;
          end
        end
      end else if (st.control[CTL_DOWN_BIT]) begin
        if (st.counter == RST_ZERO) begin
          next_st.counter = st.reload;
          upd = 1'b1;
        end else begin
          next_st.counter = st.counter - 16'h0001;
        end
      end else if (st.counter == st.reload) begin
        next_st.counter = RST_ZERO;
        upd = 1'b1;
      end else begin
        next_st.counter = st.counter + 16'h0001;
      end
      if (upd && st.control[CTL_SPM_BIT]) begin
        next_st.control[CTL_COUNT_EN_BIT] = 1'b0;
      end
    end
    if (upd) begin
      next_st.psc_count = RST_ZERO;
      next_st.upd_evt = 1'b1;
      flag_set[ST_UPDATE_BIT] = 1'b1;
      if (st.mode_a[PEN_BIT]) begin
        next_st.cmp1_active = st.cc_val[0];
      end
    end
    trg = st.event_gen[EG_TRIG_BIT] | trigger_in_i;
    next_st.trg_evt = trg;
    flag_set[ST_TRIG_BIT] = trg;
    // capture / compare channels
    for (int i = 0; i < 4; i++) begin
      if (chan_dir(2'(i), st.mode_a, st.mode_b) == DIR_OUTPUT) begin
        ch_evt = st.event_gen[EG_CH1_BIT + i]
                 | (tick && st.counter
                    == ((i == 0) ? st.cmp1_active : st.cc_val[i]));
        cap = 1'b0;
      end else begin
        cap = st.event_gen[EG_CH1_BIT + i] | ((i == 0) && ic1_edge);
        ch_evt = cap;
      end
      if (cap) begin
        next_st.cc_val[i] = st.counter;
        if (st.status[ST_CH1_BIT + i]) begin
          flag_set[ST_OVER1_BIT + i] = 1'b1;
        end
      end
      if (ch_evt) begin
        flag_set[ST_CH1_BIT + i] = 1'b1;
        next_st.irq[i] = st.int_enable[IEN_CH1_BIT + i];
        next_st.dma[i] = st.int_enable[DEN_CH1_BIT + i];
      end
    end
    // channel 1 output reference
    m1 = (tick && st.counter == st.cmp1_active)
         | (trg & st.mode_a[FEN_BIT]);
    if (dir_type'(dir1) == DIR_OUTPUT) begin
      case (cmp_mode_type'(st.mode_a[MODE_LSB +: 3]))
        CMP_FROZEN: next_st.ch1_ref = st.ch1_ref;
        CMP_SET_ON_MATCH: next_st.ch1_ref = st.ch1_ref | m1;
        CMP_CLEAR_ON_MATCH: next_st.ch1_ref = st.ch1_ref & ~m1;
        CMP_TOGGLE: next_st.ch1_ref = st.ch1_ref ^ m1;
        CMP_FORCE_LOW: next_st.ch1_ref = 1'b0;
        CMP_FORCE_HIGH: next_st.ch1_ref = 1'b1;
        CMP_PWM_ONE: next_st.ch1_ref =
          (st.counter < st.cmp1_active) | (trg & st.mode_a[FEN_BIT]);
        default: next_st.ch1_ref =
          (st.counter >= st.cmp1_active) & ~(trg & st.mode_a[FEN_BIT]);
      endcase
    end
    // register writes
    if (wr) begin
      if (avs_address_i == OFS_CONTROL) begin
        next_st.control = merge16(st.control, wd, wmask);
      end else if (avs_address_i == OFS_INT_ENABLE) begin
        next_st.int_enable = merge16(st.int_enable, wd, wmask);
      end else if (avs_address_i == OFS_STATUS) begin
        flag_clr = wmask & ~wd & ST_VALID_MASK;
      end else if (avs_address_i == OFS_EVENT_GEN) begin
        next_st.event_gen = wd & wmask & EG_VALID_MASK;
      end else if (avs_address_i == OFS_MODE_A) begin
        mode_new = merge16(st.mode_a, wd, wmask);
        if (st.ch_enable[0]) begin
          mode_new[DIR_LSB +: 2] = st.mode_a[DIR_LSB +: 2];
        end
        if (st.ch_enable[CHEN_STRIDE]) begin
          mode_new[DIR2_LSB +: 2] = st.mode_a[DIR2_LSB +: 2];
        end
        if (protect_level_i == PROTECT_FULL
            && dir_type'(dir1) == DIR_OUTPUT) begin
          mode_new[PEN_BIT] = st.mode_a[PEN_BIT];
        end
        next_st.mode_a = mode_new;
      end else if (avs_address_i == OFS_MODE_B) begin
        mode_new = merge16(st.mode_b, wd, wmask);
        if (st.ch_enable[2 * CHEN_STRIDE]) begin
          mode_new[DIR_LSB +: 2] = st.mode_b[DIR_LSB +: 2];
        end
        if (st.ch_enable[3 * CHEN_STRIDE]) begin
          mode_new[DIR2_LSB +: 2] = st.mode_b[DIR2_LSB +: 2];
        end
        next_st.mode_b = mode_new;
      end else if (avs_address_i == OFS_CH_ENABLE) begin
        next_st.ch_enable = merge16(st.ch_enable, wd, wmask);
      end else if (avs_address_i == OFS_COUNTER) begin
        next_st.counter = merge16(st.counter, wd, wmask);
      end else if (avs_address_i == OFS_PRESCALE) begin
        next_st.prescale = merge16(st.prescale, wd, wmask);
      end else if (avs_address_i == OFS_RELOAD) begin
        next_st.reload = merge16(st.reload, wd, wmask);
      end else if (cc_hit) begin
        if (chan_dir(cc_idx, st.mode_a, st.mode_b) == DIR_OUTPUT) begin
          next_st.cc_val[cc_idx] = merge16(st.cc_val[cc_idx], wd, wmask);
          if (cc_idx == 2'h0 && !st.mode_a[PEN_BIT]) begin
            next_st.cmp1_active = merge16(st.cc_val[0], wd, wmask);
          end
        end
      end
    end
    if (rd && cc_hit) begin
      flag_clr[ST_CH1_BIT + 32'(cc_idx)] = 1'b1;
    end
    // a flag set by hardware wins over a clear in the same cycle
    next_st.status = (st.status & ~flag_clr) | flag_set;
    // read mux, upper half-word and the write-only event register read zero
    if (avs_address_i == OFS_CONTROL) begin
      rmux[15:0] = st.control;
    end else if (avs_address_i == OFS_INT_ENABLE) begin
      rmux[15:0] = st.int_enable;
    end else if (avs_address_i == OFS_STATUS) begin
      rmux[15:0] = st.status;
    end else if (avs_address_i == OFS_MODE_A) begin
      rmux[15:0] = st.mode_a;
    end else if (avs_address_i == OFS_MODE_B) begin
      rmux[15:0] = st.mode_b;
    end else if (avs_address_i == OFS_CH_ENABLE) begin
      rmux[15:0] = st.ch_enable;
    end else if (avs_address_i == OFS_COUNTER) begin
      rmux[15:0] = st.counter;
    end else if (avs_address_i == OFS_PRESCALE) begin
      rmux[15:0] = st.prescale;
    end else if (avs_address_i == OFS_RELOAD) begin
      rmux[15:0] = st.reload;
    end else if (cc_hit) begin
      rmux[15:0] = st.cc_val[cc_idx];
    end
    // one wait state per access
    if ((avs_read_i | avs_write_i) && st.bus_wait) begin
      next_st.bus_wait = 1'b0;
      next_st.rdata = rmux;
    end else begin
      next_st.bus_wait = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.bus_wait <= 1'b1;
      st.reload <= RST_RELOAD;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.bus_wait;
  assign ch1_output_reference_o = st.ch1_ref;
  assign update_event_o = st.upd_evt;
  assign trigger_event_o = st.trg_evt;
  assign cc_irq_req_o = st.irq;
  assign cc_dma_req_o = st.dma;
  assign counter_value_o = st.counter;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_force_update_init: assert property (
    clk_en_i && st.event_gen[EG_UPDATE_BIT]
    |=> update_event_o && st.psc_count == 16'h0000 && st.status[0])
    else $error("forced update did not raise update event");
  a_update_bit_clear: assert property (
    clk_en_i && st.event_gen[EG_UPDATE_BIT] && !wr
    |=> !st.event_gen[EG_UPDATE_BIT])
    else $error("update bit not cleared by hardware");
  a_down_reload_load: assert property (
    clk_en_i && st.event_gen[EG_UPDATE_BIT] && st.control[4]
    && st.control[6:5] == 2'h0 && !wr
    |=> st.counter == $past(st.reload))
    else $error("forced update counting down did not load reload");
  a_out_event_irq: assert property (
    clk_en_i && st.event_gen[1] && dir1 == 2'h0 && st.int_enable[1]
    |=> cc_irq_req_o[0] && st.status[1])
    else $error("forced output event missed flag or irq");
  a_capture_copy: assert property (
    clk_en_i && st.event_gen[2] && st.mode_a[9:8] != 2'h0
    |=> st.cc_val[1] == $past(st.counter) && st.status[2])
    else $error("forced capture did not copy counter");
  a_overcapture_set: assert property (
    clk_en_i && st.event_gen[1] && dir1 != 2'h0 && st.status[1]
    |=> st.status[9])
    else $error("overcapture flag not set");
  a_dir_locked: assert property (
    clk_en_i && st.ch_enable[0] |=> dir1 == $past(dir1))
    else $error("direction changed while channel enabled");
  a_preload_protect: assert property (
    clk_en_i && protect_level_i == 2'h3 && dir1 == 2'h0
    |=> st.mode_a[3] == $past(st.mode_a[3]))
    else $error("preload bit changed under full protection");
  a_preload_hold: assert property (
    clk_en_i && st.mode_a[3] && !upd
    |=> st.cmp1_active == $past(st.cmp1_active))
    else $error("preloaded compare value moved without update");
  a_frozen_ref: assert property (
    clk_en_i && dir1 == 2'h0 && st.mode_a[6:4] == 3'h0
    |=> ch1_output_reference_o == $past(ch1_output_reference_o))
    else $error("frozen mode changed the reference");
  a_forced_low_ref: assert property (
    clk_en_i && dir1 == 2'h0 && st.mode_a[6:4] == 3'h4
    |=> !ch1_output_reference_o)
    else $error("forced low mode left reference high");
  a_event_reg_zero: assert property (
    clk_en_i && avs_read_i && st.bus_wait && avs_address_i == 8'h14
    |=> avs_readdata_o == 32'h0000_0000 && !avs_waitrequest_o)
    else $error("event register did not read zero");
endmodule : timer_event_ctrl
`default_nettype wire

// ### timer_evt_pkg.sv
`default_nettype none
package timer_evt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT_GEN = 8'h14;
  localparam logic [7:0] OFS_MODE_A = 8'h18;
  localparam logic [7:0] OFS_MODE_B = 8'h1C;
  localparam logic [7:0] OFS_CH_ENABLE = 8'h20;
  localparam logic [7:0] OFS_COUNTER = 8'h24;
  localparam logic [7:0] OFS_PRESCALE = 8'h28;
  localparam logic [7:0] OFS_RELOAD = 8'h2C;
  localparam logic [7:0] OFS_CC1 = 8'h34;
  localparam logic [7:0] OFS_CC4 = 8'h40;
  // software_event_trigger fields
  localparam int unsigned EG_UPDATE_BIT = 0;
  localparam int unsigned EG_CH1_BIT = 1;
  localparam int unsigned EG_TRIG_BIT = 6;
  localparam logic [15:0] EG_VALID_MASK = 16'h005F;
  // channel_mode_config_a / _b fields
  localparam int unsigned DIR_LSB = 0;
  localparam int unsigned FEN_BIT = 2;
  localparam int unsigned PEN_BIT = 3;
  localparam int unsigned MODE_LSB = 4;
  localparam int unsigned DIR2_LSB = 8;
  // control fields
  localparam int unsigned CTL_COUNT_EN_BIT = 0;
  localparam int unsigned CTL_SPM_BIT = 3;
  localparam int unsigned CTL_DOWN_BIT = 4;
  localparam int unsigned CTL_CENTER_LSB = 5;
  // interrupt / dma enable fields, status flag fields
  localparam int unsigned IEN_CH1_BIT = 1;
  localparam int unsigned DEN_CH1_BIT = 9;
  localparam int unsigned ST_UPDATE_BIT = 0;
  localparam int unsigned ST_CH1_BIT = 1;
  localparam int unsigned ST_TRIG_BIT = 6;
  localparam int unsigned ST_OVER1_BIT = 9;
  localparam logic [15:0] ST_VALID_MASK = 16'h1E5F;
  localparam int unsigned CHEN_STRIDE = 4;
  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [1:0] PROTECT_FULL = 2'h3;
  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'h0,
    DIR_INPUT_OWN = 2'h1,
    DIR_INPUT_NEIGHBOUR = 2'h2,
    DIR_INPUT_TRIGGER = 2'h3
  } dir_type;
  typedef enum logic [2:0] {
    CMP_FROZEN = 3'h0,
    CMP_SET_ON_MATCH = 3'h1,
    CMP_CLEAR_ON_MATCH = 3'h2,
    CMP_TOGGLE = 3'h3,
    CMP_FORCE_LOW = 3'h4,
    CMP_FORCE_HIGH = 3'h5,
    CMP_PWM_ONE = 3'h6,
    CMP_PWM_TWO = 3'h7
  } cmp_mode_type;
endpackage : timer_evt_pkg
`default_nettype wire

// ### timer_event_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_ctrl_tb;
  import timer_evt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] prot = 2'h0;
  logic tin1 = 1'b0;
  logic tin2 = 1'b0;
  logic itrg = 1'b0;
  logic trig_in = 1'b0;
  logic [31:0] rdat;
  logic wait_o, oref, upd, trg;
  logic [3:0] irq, dma;
  logic [15:0] cnt;
  logic [31:0] v;
  logic [15:0] rv;
  logic [2:0] mt[4] = '{3'h4, 3'h1, 3'h5, 3'h2};
  logic el[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 19;
  int hi, ed;
  // reference model: expected event pulse totals
  int upd_seen = 0, trg_seen = 0, exp_upd = 0, exp_trg = 0;
  int irq_seen[4] = '{0, 0, 0, 0};
  int dma_seen[4] = '{0, 0, 0, 0};
  int exp_irq[4] = '{0, 0, 0, 0};
  int exp_dma[4] = '{0, 0, 0, 0};

  timer_event_ctrl i_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'h3),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .protect_level_i(prot), .timer_input_one_i(tin1),
    .timer_input_two_i(tin2), .internal_trigger_source_i(itrg),
    .trigger_in_i(trig_in), .ch1_output_reference_o(oref),
    .update_event_o(upd), .trigger_event_o(trg),
    .cc_irq_req_o(irq), .cc_dma_req_o(dma), .counter_value_o(cnt)
  );

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  always @(posedge ref_clk_i) begin
    cycles++;
    if (!sys_rst_i) begin
      upd_seen += (upd === 1'b1);
      trg_seen += (trg === 1'b1);
      for (int i = 0; i < 4; i++) begin
        irq_seen[i] += (irq[i] === 1'b1);
        dma_seen[i] += (dma[i] === 1'b1);
      end
    end
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {16'h0000, d};
    // only the bench timeout ends a wait that never completes
    do begin
      @(posedge ref_clk_i);
    end while (wait_o !== 1'b0);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task wrt(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wrt

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    check(nm, v, e);
  endtask : rdc

  task idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle

  // samples the reference n times, counting high samples and changes
  task count_ref(input int n);
    logic p;
    p = oref;
    hi = 0;
    ed = 0;
    repeat (n) begin
      @(posedge ref_clk_i);
      hi += (oref === 1'b1);
      ed += (oref !== p);
      p = oref;
    end
  endtask : count_ref

  task check_counts;
    check("update_pulses", upd_seen, exp_upd);
    check("trigger_pulses", trg_seen, exp_trg);
    for (int i = 0; i < 4; i++) begin
      check("irq_pulses", irq_seen[i], exp_irq[i]);
      check("dma_pulses", dma_seen[i], exp_dma[i]);
    end
  endtask : check_counts

  initial begin
    idle(6);
    sys_rst_i <= 1'b0;
    rdc(OFS_EVENT_GEN, 32'h0, "event_reg_reset");
    rdc(OFS_MODE_A, 32'h0, "mode_reset");
    rdc(OFS_RELOAD, 32'h0000FFFF, "reload_reset");
    // reserved bits and zero writes do nothing
    wrt(OFS_EVENT_GEN, 16'hFFA0);
    wrt(OFS_EVENT_GEN, 16'h0000);
    idle(4);
    rdc(OFS_EVENT_GEN, 32'h0, "event_reg_reserved");
    check_counts();
    // forced update, counting up, then down, then center-aligned
    rv = 16'($random(seed));
    wrt(OFS_PRESCALE, 16'h0007);
    wrt(OFS_COUNTER, rv);
    wrt(OFS_EVENT_GEN, 16'h0001);
    exp_upd++;
    idle(4);
    rdc(OFS_COUNTER, 32'h0, "counter_up_update");
    check("counter_out", {16'h0000, cnt}, 32'h0);
    rdc(OFS_PRESCALE, 32'h7, "prescale_kept");
    rdc(OFS_EVENT_GEN, 32'h0, "update_bit_clear");
    wrt(OFS_PRESCALE, 16'h0000);
    wrt(OFS_CONTROL, 16'h0010);
    wrt(OFS_RELOAD, 16'h1234);
    wrt(OFS_COUNTER, rv);
    wrt(OFS_EVENT_GEN, 16'h0001);
    exp_upd++;
    idle(4);
    rdc(OFS_COUNTER, 32'h1234, "counter_down_update");
    wrt(OFS_CONTROL, 16'h0030);
    wrt(OFS_COUNTER, rv);
    wrt(OFS_EVENT_GEN, 16'h0001);
    exp_upd++;
    idle(4);
    rdc(OFS_COUNTER, 32'h0, "counter_center_update");
    wrt(OFS_CONTROL, 16'h0000);
    // trigger, then output channel events with and without enables
    wrt(OFS_EVENT_GEN, 16'h0040);
    exp_trg++;
    wrt(OFS_INT_ENABLE, 16'h1E1E);
    wrt(OFS_STATUS, 16'h0000);
    wrt(OFS_EVENT_GEN, 16'h001E);
    for (int i = 0; i < 4; i++) begin
      exp_irq[i]++;
      exp_dma[i]++;
    end
    idle(4);
    rdc(OFS_STATUS, 32'h001E, "output_event_flags");
    wrt(OFS_INT_ENABLE, 16'h0000);
    wrt(OFS_EVENT_GEN, 16'h001E);
    idle(4);
    check_counts();
    // forced capture on an input channel, then overcapture
    wrt(OFS_INT_ENABLE, 16'h0202);
    wrt(OFS_STATUS, 16'h0000);
    wrt(OFS_MODE_A, 16'h0001);
    wrt(OFS_COUNTER, rv);
    wrt(OFS_EVENT_GEN, 16'h0002);
    idle(4);
    rdc(OFS_STATUS, 32'h0002, "capture_flag");
    wrt(OFS_EVENT_GEN, 16'h0002);
    exp_irq[0] += 2;
    exp_dma[0] += 2;
    idle(4);
    rdc(OFS_STATUS, 32'h0202, "overcapture_flag");
    rdc(OFS_CC1, {16'h0000, rv}, "captured_value");
    rdc(OFS_STATUS, 32'h0200, "read_clears_flag");
    // every input source of channel 1
    for (int d = 1; d < 4; d++) begin
      wrt(OFS_STATUS, 16'h0000);
      wrt(OFS_MODE_A, 16'(d));
      if (d == 1) tin1 <= 1'b1;
      else if (d == 2) tin2 <= 1'b1;
      else itrg <= 1'b1;
      idle(4);
      tin1 <= 1'b0;
      tin2 <= 1'b0;
      itrg <= 1'b0;
      idle(6);
      exp_irq[0]++;
      exp_dma[0]++;
      rdc(OFS_STATUS, 32'h0002, "input_source_capture");
    end
    // forced capture on channel 2 as an input
    wrt(OFS_STATUS, 16'h0000);
    wrt(OFS_MODE_A, 16'h0103);
    wrt(OFS_EVENT_GEN, 16'h0004);
    idle(4);
    rdc(OFS_STATUS, 32'h0004, "ch2_capture_flag");
    rdc(OFS_CC1 + 8'h04, {16'h0000, rv}, "ch2_captured");
    // direction locked while the channel is enabled
    wrt(OFS_CH_ENABLE, 16'h0001);
    wrt(OFS_MODE_A, 16'h0000);
    rdc(OFS_MODE_A, 32'h3, "dir_locked");
    wrt(OFS_CH_ENABLE, 16'h0000);
    wrt(OFS_MODE_A, 16'h0000);
    rdc(OFS_MODE_A, 32'h0, "dir_unlocked");
    // preload bit locked at full protection
    prot <= PROTECT_FULL;
    wrt(OFS_MODE_A, 16'h0008);
    rdc(OFS_MODE_A, 32'h0, "preload_locked");
    prot <= 2'h0;
    wrt(OFS_MODE_A, 16'h0008);
    rdc(OFS_MODE_A, 32'h8, "preload_written");
    wrt(OFS_INT_ENABLE, 16'h0000);
    check_counts();
    // immediate and preloaded compare writes, single-pulse while unbuffered
    wrt(OFS_RELOAD, 16'hFFFF);
    wrt(OFS_COUNTER, 16'h0000);
    wrt(OFS_CC1, 16'h0000);
    wrt(OFS_MODE_A, 16'h0060);
    wrt(OFS_CONTROL, 16'h0009);
    idle(10);
    check("pwm_low", {31'h0, oref}, 32'h0);
    wrt(OFS_CC1, 16'hFFFF);
    idle(5);
    check("compare_immediate", {31'h0, oref}, 32'h1);
    wrt(OFS_CC1, 16'h0000);
    idle(5);
    wrt(OFS_MODE_A, 16'h0068);
    wrt(OFS_CC1, 16'hFFFF);
    count_ref(30);
    check("compare_held", hi, 0);
    wrt(OFS_EVENT_GEN, 16'h0001);
    idle(6);
    check("compare_loaded", {31'h0, oref}, 32'h1);
    // compare modes on a 16-count period
    wrt(OFS_CONTROL, 16'h0000);
    wrt(OFS_RELOAD, 16'h000F);
    wrt(OFS_COUNTER, 16'h0000);
    wrt(OFS_CC1, 16'h0005);
    wrt(OFS_CONTROL, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wrt(OFS_MODE_A, {9'h000, mt[i], 4'h8});
      idle(40);
      check("ref_mode", {31'h0, oref}, {31'h0, el[i]});
    end
    wrt(OFS_MODE_A, 16'h0038);
    idle(20);
    count_ref(64);
    check("toggle_edges", ed, 4);
    wrt(OFS_MODE_A, 16'h0008);
    idle(4);
    count_ref(64);
    check("frozen_edges", ed, 0);
    wrt(OFS_MODE_A, 16'h0068);
    idle(20);
    count_ref(64);
    check("pwm1_high", hi, 20);
    wrt(OFS_MODE_A, 16'h0078);
    idle(20);
    count_ref(64);
    check("pwm2_high", hi, 44);
    // a trigger acts on a stopped PWM1 reference only with fast enable
    wrt(OFS_CONTROL, 16'h0000);
    wrt(OFS_COUNTER, 16'h000A);
    for (int f = 1; f >= 0; f--) begin
      wrt(OFS_MODE_A, 16'h0068 | 16'(f << FEN_BIT));
      trig_in <= 1'b1;
      idle(1);
      trig_in <= 1'b0;
      count_ref(8);
      check("fast_trigger", hi, f);
    end
    wrap_up();
  end
endmodule : timer_event_ctrl_tb
`default_nettype wire
